// ==== verilog/hcs_ctrl.sv ====
// Halt and clock stop controller with Avalon-MM register slave
`default_nettype none
module hcs_ctrl
  import hcs_pkg::*;
#(
  parameter int unsigned KEYS      = 4,
  parameter int unsigned NIRQ      = 4,
  parameter int unsigned MS_CYCLES = HCS_MS_CYCLES
) (
  input  wire logic                    CLK_I,              // System clock, 50 MHz
  input  wire logic                    RST_I,              // Synchronous reset, high
  input  wire logic [2:0]              AVS_ADDRESS_I,      // Word address
  input  wire logic                    AVS_READ_I,         // Read request
  input  wire logic                    AVS_WRITE_I,        // Write request
  input  wire logic [31:0]             AVS_WRITEDATA_I,    // Write data
  output logic      [31:0]             AVS_READDATA_O,     // Read data
  output logic                         AVS_WAITREQUEST_O,  // Wait request
  input  wire logic                    HALT_EXEC_I,        // Halt instruction pulse
  input  wire logic [3:0]              HALT_OPND_I,        // Halt operand
  input  wire logic                    STOP_EXEC_I,        // Stop instruction pulse
  input  wire logic [3:0]              STOP_OPND_I,        // Stop operand
  input  wire logic [KEYS-1:0]         KEY_I,              // Key input port
  input  wire logic                    CE_I,               // Chip enable level
  input  wire logic [NIRQ-1:0]         IRQ_I,              // Interrupt requests
  input  wire logic                    POR_I,              // Power-on reset pulse
  output logic                         CPU_RUN_O,          // Processor clock enable
  output logic                         OSC_EN_O,           // Oscillator enable
  output logic                         PERIPH_RUN_O,       // Peripheral enable
  output logic                         PF_DET_EN_O,        // Power-fail detect enable
  output logic                         INT_ACK_O,          // Interrupt ack pulse
  output logic [$clog2(NIRQ)-1:0]      INT_SRC_O,          // Acknowledged source
  output logic                         WAKE_O,             // Halt release pulse
  output logic                         CE_RESET_O,         // Chip-enable reset pulse
  output logic                         TMR_CARRY_O         // Timer carry flag
);

  localparam int unsigned IW = $clog2(NIRQ);

  hcs_bus_req_t           req;
  logic                   wait_r;
  logic [31:0]            rdata_r;
  logic [1:0]             sel_r;
  logic                   gie_r;
  logic [NIRQ-1:0]        permit_r;
  logic                   timer_carry_flag_r;
  logic [15:0]            sub_r;
  logic [6:0]             ms_r;
  logic                   tset;
  logic                   tset_r;
  logic                   halted_r;
  logic [3:0]             cond_r;
  logic                   stop_r;
  logic                   ce_d_r;
  logic                   ce_arm_r;
  logic                   acc_prev_r;
  logic                   int_ack_r;
  logic [IW-1:0]          int_src_r;
  logic                   wake_r;
  logic                   ce_rst_r;
  logic                   run_r;
  logic                   osc_r;
  logic                   per_r;
  logic                   pfd_r;
  hcs_cause_t             cause_r;
  logic                   acc;
  logic [NIRQ-1:0]        acc_vec;
  logic                   ce_rise;
  logic                   rel_key;
  logic                   rel_tmr;
  logic                   rel_int;
  logic                   rel;
  logic                   halt_go;
  logic                   stop_go;
  logic                   bus_do;
  logic                   wr_ctrl;
  logic                   wr_stat;
  logic                   sys_rst;

  // Interval lookup used by divider and reload
  function automatic logic [6:0] interval_ms(input logic [1:0] sel);
    case (sel)
      2'h0:    interval_ms = 7'(HCS_T_SET0_MS);
      2'h1:    interval_ms = 7'(HCS_T_SET1_MS);
      2'h2:    interval_ms = 7'(HCS_T_SET2_MS);
      default: interval_ms = 7'(HCS_T_SET3_MS);
    endcase
  endfunction : interval_ms

  // Lowest index wins
  function automatic logic [IW-1:0] first_src(input logic [NIRQ-1:0] v);
    first_src = '0;
    for (int i = NIRQ - 1; i >= 0; i--) begin
      if (v[i]) begin
        first_src = IW'(i);
      end
    end
  endfunction : first_src

  assign req      = '{address: AVS_ADDRESS_I, read: AVS_READ_I, write: AVS_WRITE_I, writedata: AVS_WRITEDATA_I};
  assign sys_rst  = RST_I | POR_I;
  assign bus_do   = (req.read | req.write) & ~wait_r;
  assign wr_ctrl  = bus_do & req.write & (req.address == HCS_REG_CTRL);
  assign wr_stat  = bus_do & req.write & (req.address == HCS_REG_STATUS);
  assign acc_vec  = IRQ_I & permit_r & {NIRQ{gie_r}};
  assign acc      = |acc_vec;
  assign ce_rise  = CE_I & ~ce_d_r;
  assign rel_key  = cond_r[HCS_HB_KEY] & (|KEY_I);
  assign rel_tmr  = cond_r[HCS_HB_TMR] & timer_carry_flag_r;
  assign rel_int  = cond_r[HCS_HB_INT] & acc;
  // A chip-enable reset clears the halt itself and is not reported as a wake
  assign rel      = halted_r & ~stop_r & ~ce_rst_r & (rel_key | rel_tmr | rel_int);
  // Old interrupt state blocks a halt that selects interrupt release; software inserts a spacer instruction
  assign halt_go  = HALT_EXEC_I & ~halted_r & ~stop_r
                  & ~(HALT_OPND_I[HCS_HB_INT] & acc_prev_r);
  assign stop_go  = STOP_EXEC_I & (STOP_OPND_I == HCS_STOP_OPND)
                  & ~CE_I & ~stop_r;
  // Divider frozen with the oscillator
  assign tset     = ~stop_r & (sub_r == 16'(MS_CYCLES - 1)) & (ms_r == 7'h0);

  // Avalon slave: one wait state on every access
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      wait_r <= 1'b1;
    end else begin
      wait_r <= ~((req.read | req.write) & wait_r);
    end
  end

  // Captured in the wait cycle so the data stand at the completing edge
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      rdata_r <= 32'h0;
    end else if (req.read & wait_r) begin
      case (req.address)
        HCS_REG_CTRL:   rdata_r <= {27'h0, gie_r, 2'h0, sel_r};
        HCS_REG_PERMIT: rdata_r <= 32'(permit_r);
        HCS_REG_STATUS: rdata_r <= {27'h0, pfd_r, stop_r, halted_r, ce_d_r, timer_carry_flag_r};
        HCS_REG_CAUSE:  rdata_r <= {29'h0, cause_r};
        default:        rdata_r <= 32'h0;
      endcase
    end
  end

  // Control registers; stop entry restores the 100 ms interval
  always_ff @(posedge CLK_I) begin
    if (sys_rst) begin
      sel_r    <= HCS_SEL_RST;
      gie_r    <= HCS_GIE_RST;
      permit_r <= '0;
    end else if (stop_go) begin
      sel_r    <= HCS_SEL_RST;
    end else begin
      if (wr_ctrl) begin
        sel_r <= req.writedata[HCS_CTRL_SEL_LO +: 2];
        gie_r <= req.writedata[HCS_CTRL_GIE];
      end
      if (bus_do & req.write & (req.address == HCS_REG_PERMIT)) begin
        permit_r <= req.writedata[NIRQ-1:0];
      end
    end
  end

  // Timer divider: ms prescaler and interval counter
  always_ff @(posedge CLK_I) begin
    if (sys_rst | stop_go | wr_ctrl) begin
      sub_r <= 16'h0;
      ms_r  <= 7'(HCS_T_SET0_MS - 1);
    end else if (~stop_r) begin
      if (sub_r == 16'(MS_CYCLES - 1)) begin
        sub_r <= 16'h0;
        ms_r  <= (ms_r == 7'h0) ? interval_ms(sel_r) - 7'h1 : ms_r - 7'h1;
      end else begin
        sub_r <= sub_r + 16'h1;
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (sys_rst) begin
      tset_r <= 1'b0;
    end else begin
      tset_r <= tset;
    end
  end

  // Timer carry flag: write 1 clears, a set in the same cycle wins
  always_ff @(posedge CLK_I) begin
    if (sys_rst | stop_go) begin
      timer_carry_flag_r <= 1'b0;
    end else if (tset_r) begin
      timer_carry_flag_r <= 1'b1;
    end else if (wr_stat & req.writedata[HCS_ST_TIMER_CARRY_FLAG]) begin
      timer_carry_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      acc_prev_r <= 1'b0;
      ce_d_r     <= 1'b0;
    end else begin
      acc_prev_r <= acc;
      ce_d_r     <= CE_I;
    end
  end

  // Halt state; stop forces a halt released by the timer carry pulse
  always_ff @(posedge CLK_I) begin
    if (sys_rst | ce_rst_r) begin
      halted_r <= 1'b0;
      cond_r   <= 4'h0;
    end else if (stop_go) begin
      halted_r <= 1'b1;
      cond_r   <= HCS_FORCED_HALT;
    end else if (halt_go) begin
      halted_r <= 1'b1;
      cond_r   <= HALT_OPND_I & ~(4'h1 << HCS_HB_UNUSED);
    end else if (rel) begin
      halted_r <= 1'b0;
    end
  end

  // Clock stop ends on chip enable rise or power-on reset
  always_ff @(posedge CLK_I) begin
    if (sys_rst) begin
      stop_r <= 1'b0;
    end else if (stop_go) begin
      stop_r <= 1'b1;
    end else if (ce_rise) begin
      stop_r <= 1'b0;
    end
  end

  // Chip enable reset waits for the next timer carry set pulse
  // Any rise arms it, so a stop taken as a no-operation still ends in a reset
  always_ff @(posedge CLK_I) begin
    if (sys_rst) begin
      ce_arm_r <= 1'b0;
      ce_rst_r <= 1'b0;
    end else begin
      ce_rst_r <= ce_arm_r & tset_r;
      if (ce_rise) begin
        ce_arm_r <= 1'b1;
      end else if (tset_r) begin
        ce_arm_r <= 1'b0;
      end
    end
  end

  // Release reporting; source index lets the processor vector
  always_ff @(posedge CLK_I) begin
    if (sys_rst) begin
      wake_r    <= 1'b0;
      int_ack_r <= 1'b0;
      int_src_r <= '0;
      cause_r   <= '0;
    end else begin
      wake_r    <= rel;
      int_ack_r <= rel & rel_int;
      if (rel & rel_int) begin
        int_src_r <= first_src(acc_vec);
      end
      if (rel) begin
        cause_r <= '{intr: rel_int, tmr: rel_tmr, key: rel_key};
      end
    end
  end

  // Enables for processor, oscillator, peripherals and power-fail logic
  always_ff @(posedge CLK_I) begin
    if (sys_rst) begin
      run_r <= 1'b1;
      osc_r <= 1'b1;
      per_r <= 1'b0;
      pfd_r <= 1'b1;
    end else begin
      run_r <= ~((halted_r & ~rel) | halt_go | stop_go) | ce_rst_r;
      osc_r <= ~((stop_r & ~ce_rise) | stop_go);
      per_r <= CE_I & ~((stop_r & ~ce_rise) | stop_go);
      pfd_r <= ~((stop_r & ~ce_rise) | stop_go);
    end
  end

  assign AVS_READDATA_O    = rdata_r;
  assign AVS_WAITREQUEST_O = wait_r;
  assign CPU_RUN_O         = run_r;
  assign OSC_EN_O          = osc_r;
  assign PERIPH_RUN_O      = per_r;
  assign PF_DET_EN_O       = pfd_r;
  assign INT_ACK_O         = int_ack_r;
  assign INT_SRC_O         = int_src_r;
  assign WAKE_O            = wake_r;
  assign CE_RESET_O        = ce_rst_r;
  assign TMR_CARRY_O       = timer_carry_flag_r;

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (sys_rst);

  key_release_a: assert property (halted_r & ~stop_r & ~ce_rst_r & rel_key |=> ~halted_r && WAKE_O)
    else $error("key input did not release halt");
  timer_release_a: assert property (halted_r & ~stop_r & cond_r[1] & timer_carry_flag_r |=> ~halted_r)
    else $error("timer carry did not release halt");
  carry_kept_a: assert property (timer_carry_flag_r & ~tset_r & ~wr_stat & ~stop_go |=> timer_carry_flag_r)
    else $error("timer carry flag lost");
  int_gate_a: assert property (INT_ACK_O |-> $past(gie_r)
                               && (($past(permit_r & IRQ_I) >> INT_SRC_O) & NIRQ'(1)) != '0)
    else $error("interrupt acknowledged without enable");
  no_release_a: assert property (halted_r & ~stop_r & ~rel_key & ~rel_tmr & ~rel_int & ~ce_rst_r |=> halted_r)
    else $error("halt left with no selected condition");
  empty_halt_a: assert property (halt_go & (HALT_OPND_I & 4'hb) == 4'h0 |=> halted_r ##1 halted_r)
    else $error("empty halt released");
  old_irq_a: assert property (HALT_EXEC_I & HALT_OPND_I[3] & acc_prev_r & ~halted_r & ~stop_r |=> ~halted_r)
    else $error("halt entered on stale interrupt");
  stop_nop_a: assert property (STOP_EXEC_I & CE_I & ~stop_r |=> ~stop_r && OSC_EN_O)
    else $error("stop acted with chip enable high");
  stop_freeze_a: assert property (stop_go |=> ~OSC_EN_O && ~CPU_RUN_O && ~PERIPH_RUN_O && ~PF_DET_EN_O)
    else $error("stop did not freeze device");
  ce_wake_a: assert property (stop_r & ce_rise |=> ~stop_r ##1 OSC_EN_O)
    else $error("chip enable rise left clock stopped");
  ce_reset_a: assert property (ce_arm_r & tset_r & ~ce_rise |=> CE_RESET_O ##1 ~CE_RESET_O)
    else $error("chip enable reset not on carry pulse");
  resume_a: assert property (rel |=> CPU_RUN_O)
    else $error("processor did not resume after release");
  carry_set_a: assert property (tset_r & ~stop_go |=> TMR_CARRY_O)
    else $error("timer carry flag not set by pulse");
  ack_wake_a: assert property (INT_ACK_O |-> WAKE_O)
    else $error("interrupt acknowledged without release");
  stop_operand_a: assert property (STOP_EXEC_I & (STOP_OPND_I != HCS_STOP_OPND) & ~stop_r |=> ~stop_r)
    else $error("stop acted with a nonzero operand");
  ce_halt_a: assert property (CE_RESET_O |=> ~halted_r)
    else $error("chip enable reset left halt set");
  pfd_stop_a: assert property (stop_r & ~ce_rise |=> ~PF_DET_EN_O)
    else $error("power-fail detection active in clock stop");
  periph_ce_a: assert property (~CE_I |=> ~PERIPH_RUN_O)
    else $error("peripherals ran with chip enable low");
  // Holds for any master: a request seen in a wait cycle always drops waitrequest on the next cycle
  bus_wait_a: assert property ((AVS_READ_I | AVS_WRITE_I) & AVS_WAITREQUEST_O |=> ~AVS_WAITREQUEST_O)
    else $error("bus access not answered after one wait state");

  key_wake_c:  cover property (halted_r ##1 rel_key ##1 WAKE_O);
  timer_wake_c: cover property (halted_r & cond_r[HCS_HB_TMR] ##1 rel_tmr ##1 WAKE_O);
  int_wake_c:  cover property (halted_r ##1 rel_int ##1 INT_ACK_O);
  stop_ce_c:   cover property (stop_go ##[1:1000] ce_rise);
  nop_reset_c: cover property (STOP_EXEC_I & CE_I ##[1:1000] CE_RESET_O);

endmodule : hcs_ctrl
`default_nettype wire

// ==== verilog/hcs_pkg.sv ====
// Constants, register map and carrier types for the halt and clock stop controller
`default_nettype none
package hcs_pkg;
  // System clock
  localparam int unsigned HCS_CLK_HZ        = 50_000_000;
  localparam int unsigned HCS_MS_PER_S      = 1000;
  localparam int unsigned HCS_MS_CYCLES     = HCS_CLK_HZ / HCS_MS_PER_S;
  // Timer carry set intervals, in ms
  localparam int unsigned HCS_T_SET0_MS     = 100;
  localparam int unsigned HCS_T_SET1_MS     = 50;
  localparam int unsigned HCS_T_SET2_MS     = 5;
  localparam int unsigned HCS_T_SET3_MS     = 1;
  // Halt operand bits
  localparam int unsigned HCS_HB_KEY        = 0;
  localparam int unsigned HCS_HB_TMR        = 1;
  localparam int unsigned HCS_HB_UNUSED     = 2;
  localparam int unsigned HCS_HB_INT        = 3;
  localparam logic [3:0]  HCS_STOP_OPND     = 4'h0;
  localparam logic [3:0]  HCS_FORCED_HALT   = 4'h2;
  // Register word addresses
  localparam logic [2:0]  HCS_REG_CTRL      = 3'h0;
  localparam logic [2:0]  HCS_REG_PERMIT    = 3'h1;
  localparam logic [2:0]  HCS_REG_STATUS    = 3'h2;
  localparam logic [2:0]  HCS_REG_CAUSE     = 3'h3;
  // CTRL fields
  localparam int unsigned HCS_CTRL_SEL_LO   = 0;
  localparam int unsigned HCS_CTRL_GIE      = 4;
  // STATUS fields
  localparam int unsigned HCS_ST_TIMER_CARRY_FLAG       = 0;
  localparam int unsigned HCS_ST_CE         = 1;
  localparam int unsigned HCS_ST_HALT       = 2;
  localparam int unsigned HCS_ST_STOP       = 3;
  localparam int unsigned HCS_ST_PFD        = 4;
  // Reset values
  localparam logic [1:0]  HCS_SEL_RST       = 2'h0;
  localparam logic        HCS_GIE_RST       = 1'b0;

  typedef struct packed {
    logic intr;
    logic tmr;
    logic key;
  } hcs_cause_t;

  typedef struct packed {
    logic [2:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
  } hcs_bus_req_t;
endpackage : hcs_pkg
`default_nettype wire

// ==== verification/hcs_keysw.sv ====
// Behavioural key switches and chip-enable line facing the controller
`default_nettype none
module hcs_keysw (
  input  wire logic       clk_i,    // System clock
  input  wire logic       press_i,  // Key held down by the bench
  input  wire logic [3:0] lag_i,    // Cycles before the contact closes
  input  wire logic [1:0] pin_i,    // Key that closes
  input  wire logic       ce_i,     // Requested chip-enable level
  output logic      [3:0] key_o,    // Key port pins
  output logic            ce_o      // Chip-enable line
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  initial begin
    key_o = 4'h0;
    ce_o  = 1'b0;
  end
  // Slow contacts: a press only shows after the requested lag
  always @(posedge clk_i) begin
    cnt   <= press_i ? cnt + 1 : 0;
    // Open keys read low through the port pull-downs
    key_o <= (press_i && cnt >= int'(lag_i)) ? 4'h1 << pin_i : 4'h0;
    ce_o  <= ce_i;
  end
endmodule : hcs_keysw
`default_nettype wire

// ==== verification/hcs_ctrl_bench.sv ====
// Self-checking bench for the halt and clock stop controller
`default_nettype none
module hcs_ctrl_bench;
  import hcs_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {string what; logic [1:0] kind; logic [31:0] val;} hcs_note_t;
  logic         clk, rst, halt_x, stop_x, por, press, ce_cmd, ce;
  logic         wreq, ack, wake, ce_rst, run, osc, prun, pfd, timer_carry_flag;
  logic [3:0]   halt_op, stop_op, keys, irq, lag, p, ir, es;
  logic [1:0]   pin, src;
  logic [31:0]  rdata;
  hcs_bus_req_t bus;
  hcs_note_t    q[$];
  int           errors = 0;
  int           checks = 0;
  int           cyc = 0;

  hcs_ctrl #(.KEYS(4), .NIRQ(4), .MS_CYCLES(4)) dut (
    .CLK_I(clk), .RST_I(rst), .AVS_ADDRESS_I(bus.address), .AVS_READ_I(bus.read),
    .AVS_WRITE_I(bus.write), .AVS_WRITEDATA_I(bus.writedata), .AVS_READDATA_O(rdata),
    .AVS_WAITREQUEST_O(wreq), .HALT_EXEC_I(halt_x), .HALT_OPND_I(halt_op), .STOP_EXEC_I(stop_x),
    .STOP_OPND_I(stop_op), .KEY_I(keys), .CE_I(ce), .IRQ_I(irq), .POR_I(por), .CPU_RUN_O(run),
    .OSC_EN_O(osc), .PERIPH_RUN_O(prun), .PF_DET_EN_O(pfd), .INT_ACK_O(ack), .INT_SRC_O(src),
    .WAKE_O(wake), .CE_RESET_O(ce_rst), .TMR_CARRY_O(timer_carry_flag));
  hcs_keysw sw (.clk_i(clk), .press_i(press), .lag_i(lag), .pin_i(pin), .ce_i(ce_cmd), .key_o(keys), .ce_o(ce));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic results;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results

  // Whole run is about 1500 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      errors++;
      $display("BAD run time expected below 10000 seen %0d", cyc);
      results();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic take(input logic [1:0] kind, input logic [31:0] val);
    hcs_note_t n;
    checks++;
    if (q.size() == 0) begin
      errors++;
      $display("BAD event %0d expected none seen %h", kind, val);
    end else begin
      n = q.pop_front();
      if (n.kind !== kind || n.val !== val) begin
        errors++;
        $display("BAD %s expected %h seen %h", n.what, n.val, val);
      end
    end
  endtask : take

  // Results appear as completed reads, wake pulses and chip-enable resets
  always @(posedge clk) begin
    if (!rst && bus.read && wreq === 1'b0) take(2'd0, rdata);
    if (!rst && wake === 1'b1) take(2'd1, ack === 1'b1 ? {29'h0, 1'b1, src} : 32'h0);
    if (!rst && ce_rst === 1'b1) take(2'd2, 32'h0);
  end

  task automatic note(input string what, input logic [1:0] kind, input logic [31:0] val);
    q.push_back('{what, kind, val});
  endtask : note

  task automatic waitq(input int n);
    int i = 0;
    while (q.size() != 0 && i < n) begin
      @(posedge clk);
      i++;
    end
    if (q.size() != 0) begin
      errors++;
      $display("BAD %s expected %h seen none", q[0].what, q[0].val);
      q.delete();
    end
    #1;
  endtask : waitq

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  // Request held until the edge that samples waitrequest low
  task automatic bus_op(input logic [2:0] a, input logic wr, input logic [31:0] d);
    @(posedge clk);
    bus <= '{address: a, read: !wr, write: wr, writedata: d};
    do @(posedge clk); while (wreq !== 1'b0);
    bus <= '0;
  endtask : bus_op

  task automatic rd(input string what, input logic [2:0] a, input logic [31:0] exp);
    note(what, 2'd0, exp);
    bus_op(a, 1'b0, 32'h0);
  endtask : rd

  task automatic halt(input logic [3:0] op);
    @(posedge clk);
    halt_x  <= 1'b1;
    halt_op <= op;
    @(posedge clk);
    halt_x  <= 1'b0;
    #1;
  endtask : halt

  task automatic stop(input logic [3:0] op);
    @(posedge clk);
    stop_x  <= 1'b1;
    stop_op <= op;
    @(posedge clk);
    stop_x  <= 1'b0;
    #1;
  endtask : stop

  task automatic pwr_on;
    @(posedge clk);
    por <= 1'b1;
    @(posedge clk);
    por <= 1'b0;
    tick(1);
  endtask : pwr_on

  initial begin
    rst     = 1'b1;
    bus     = '0;
    halt_x  = 1'b0;
    halt_op = 4'h0;
    stop_x  = 1'b0;
    stop_op = 4'h0;
    irq     = 4'h0;
    por     = 1'b0;
    press   = 1'b0;
    lag     = 4'h0;
    pin     = 2'h0;
    ce_cmd  = 1'b0;
    void'($urandom(24313));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    tick(1);
    chk("run after reset", 32'h1, run);
    chk("osc after reset", 32'h1, osc);
    chk("pfd after reset", 32'h1, pfd);
    rd("ctrl reset", HCS_REG_CTRL, {27'h0, HCS_GIE_RST, 2'h0, HCS_SEL_RST});
    rd("unmapped", 3'h5, 32'h0);
    rd("status reset", HCS_REG_STATUS, 32'h1 << HCS_ST_PFD);
    $display("test reset done");
    lag = 4'($urandom_range(7, 1));
    pin = 2'($urandom);
    halt(4'h1);
    chk("run halted", 32'h0, run);
    note("key wake", 2'd1, 32'h0);
    @(posedge clk) press <= 1'b1;
    waitq(20);
    chk("run after key", 32'h1, run);
    rd("cause key", HCS_REG_CAUSE, 32'h1);
    @(posedge clk) press <= 1'b0;
    $display("test key done");
    for (int i = 0; i < 2; i++) begin
      begin
        lag = 4'h0;
        @(posedge clk) press <= 1'b1;
        // Held key must not wake a halt without release bits
        halt(i == 0 ? 4'h0 : 4'h4);
        tick(30);
        chk("run no release", 32'h0, run);
        pwr_on();
        chk("run after por", 32'h1, run);
        @(posedge clk) press <= 1'b0;
      end
    end
    $display("test no release done");
    bus_op(HCS_REG_CTRL, 1'b1, 32'h0);
    bus_op(HCS_REG_STATUS, 1'b1, 32'h1);
    halt(4'h2);
    chk("run timer halt", 32'h0, run);
    note("timer wake", 2'd1, 32'h0);
    waitq(420);
    chk("flag kept", 32'h1, timer_carry_flag);
    note("timer rewake", 2'd1, 32'h0);
    halt(4'h2);
    waitq(4);
    rd("cause timer", HCS_REG_CAUSE, 32'h2);
    bus_op(HCS_REG_STATUS, 1'b1, 32'h1);
    rd("status cleared", HCS_REG_STATUS, 32'h1 << HCS_ST_PFD);
    $display("test timer done");
    p = 4'($urandom_range(15, 1));
    do ir = 4'($urandom); while ((ir & p) == 4'h0);
    for (int i = 3; i >= 0; i--) if (ir[i] && p[i]) es = 4'(i);
    bus_op(HCS_REG_PERMIT, 1'b1, {28'h0, p});
    bus_op(HCS_REG_CTRL, 1'b1, 32'h1 << HCS_CTRL_GIE);
    @(posedge clk) irq <= ir;
    halt(4'h8);
    chk("halt ignored", 32'h1, run);
    for (int v = 0; v < 2; v++) begin
      bus_op(HCS_REG_PERMIT, 1'b1, v == 1 ? {28'h0, p} : 32'h0);
      bus_op(HCS_REG_CTRL, 1'b1, v == 1 ? 32'h0 : 32'h1 << HCS_CTRL_GIE);
      halt(4'h8);
      tick(10);
      chk("run masked irq", 32'h0, run);
      note("irq wake", 2'd1, {29'h0, 1'b1, es[1:0]});
      bus_op(v == 1 ? HCS_REG_CTRL : HCS_REG_PERMIT, 1'b1, v == 1 ? 32'h1 << HCS_CTRL_GIE : {28'h0, p});
      waitq(10);
      rd("cause irq", HCS_REG_CAUSE, 32'h4);
    end
    @(posedge clk) irq <= 4'h0;
    bus_op(HCS_REG_CTRL, 1'b1, 32'h0);
    bus_op(HCS_REG_STATUS, 1'b1, 32'h1);
    halt(4'hb);
    note("multi wake", 2'd1, 32'h0);
    @(posedge clk) press <= 1'b1;
    waitq(20);
    rd("cause multi", HCS_REG_CAUSE, 32'h1);
    @(posedge clk) press <= 1'b0;
    $display("test interrupt done");
    stop(4'h5);
    chk("osc other operand", 32'h1, osc);
    stop(HCS_STOP_OPND);
    chk("osc stopped", 32'h0, osc);
    chk("run stopped", 32'h0, run);
    chk("periph stopped", 32'h0, prun);
    chk("pfd stopped", 32'h0, pfd);
    pwr_on();
    chk("osc after por", 32'h1, osc);
    chk("pfd after por", 32'h1, pfd);
    stop(HCS_STOP_OPND);
    tick(2);
    note("ce reset", 2'd2, 32'h0);
    @(posedge clk) ce_cmd <= 1'b1;
    tick(4);
    chk("osc after ce", 32'h1, osc);
    waitq(420);
    chk("periph running", 32'h1, prun);
    @(posedge clk) ce_cmd <= 1'b0;
    tick(4);
    note("ce reset nop", 2'd2, 32'h0);
    @(posedge clk) ce_cmd <= 1'b1;
    tick(4);
    stop(HCS_STOP_OPND);
    chk("osc ce high", 32'h1, osc);
    waitq(420);
    $display("test stop done");
    results();
  end
endmodule : hcs_ctrl_bench
`default_nettype wire
